/* File: clk_select_defs.vh */
// Constants for the system and USB clock source selection block
`ifndef CLK_SELECT_DEFS_VH
`define CLK_SELECT_DEFS_VH

// Register address on the special-function-register bus
`define CSS_ADDR            8'hA9
`define CSS_RESET           8'h00
// Field positions
`define SYS_FIELD_HI        2
`define SYS_FIELD_LO        0
`define OUT_SYNC_BIT        3
`define USB_FIELD_HI        6
`define USB_FIELD_LO        4
`define WRITE_MASK          8'h7F
// System clock source codes
`define SYS_HF_SCALED       3'h0
`define SYS_EXT             3'h1
`define SYS_HF_DIV2         3'h2
`define SYS_HF_FULL         3'h3
`define SYS_LF_SCALED       3'h4
// USB clock source codes
`define USB_HF_FULL         3'h0
`define USB_HF_DIV8         3'h1
`define USB_EXT_FULL        3'h2
`define USB_EXT_DIV2        3'h3
`define USB_EXT_DIV3        3'h4
`define USB_EXT_DIV4        3'h5
`define USB_LF_FULL         3'h6
// High-frequency divider codes
`define HFDIV_8             2'h0
`define HFDIV_4             2'h1
`define HFDIV_2             2'h2
`define HFDIV_1             2'h3
// Divider counter widths and limits
`define DIV_CNT_W           5
`define PRE_DIV4_LAST       5'h03
`define DIV1_LAST           5'h00
`define DIV2_LAST           5'h01
`define DIV3_LAST           5'h02
`define DIV4_LAST           5'h03
`define DIV8_LAST           5'h07
`define DIV16_LAST          5'h0F
`define DIV32_LAST          5'h1F
`define LF_DIV_W            2

`endif

/* File: clk_enable_div.v */
// Divide-by-N enable pulse generator driven by a source tick
`timescale 1ns/1ps
module clk_enable_div (
    // Clock and reset
    input  wire       ref_clk_i,
    input  wire       srst_i,
    // Source tick and divide control
    input  wire       tick_i,
    input  wire [4:0] last_i,
    // Divided tick output
    output wire       tick_o
);
    reg [4:0] count;    // Ticks seen in the current period

    // Count source ticks, wrap at the last index
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            count <= 5'h00;
        end else if (tick_i) begin
            if (count >= last_i) begin
                count <= 5'h00;
            end else begin
                count <= count + 5'h01;
            end
        end
    end

    // One pulse per period, on the wrapping tick
    assign tick_o = tick_i && (count >= last_i);
endmodule // clk_enable_div

/* File: clock_source_select_top.v */
// Clock source selection for the system and USB clocks with its control register
//
// Functional notes
// - Code 000 selects HF oscillator via divider
// - Code 001 selects external oscillator directly
// - Code 010 selects HF oscillator halved
// - Code 011 selects undivided HF oscillator
// - Code 100 selects LF oscillator via divider
// - USB field bits 6:4; 000 undivided HF
// - USB code 001 gives HF divided by eight
// - USB 010 external, 011 external halved
// - USB 100 external/3, 101 external/4
// - USB 110 LF oscillator; 111 reserved
// - Bit 3 picks raw or synchronized pin clock
// - Bit 7 reads zero, writes ignored
// - External oscillator always offered to peripherals
// - HF fixed /4 then /8,/4,/2,/1
// - HF oscillator base is 48 MHz
//
// Oscillators arrive as one-cycle ticks on ref_clk_i; each selected clock
// leaves as a tick stream, which keeps the whole block in one domain.
`timescale 1ns/1ps
`include "clk_select_defs.vh"
module clock_source_select_top (
    // Clock and reset
    input  wire       ref_clk_i,
    input  wire       srst_i,
    // Special-function-register bus
    input  wire [7:0] sfr_addr_i,
    input  wire [7:0] sfr_wdata_i,
    input  wire       sfr_wr_i,
    input  wire       sfr_rd_i,
    output wire [7:0] sfr_rdata_o,
    // Oscillator source ticks
    input  wire       hf_osc_tick_i,
    input  wire       ext_osc_tick_i,
    input  wire       lf_osc_tick_i,
    // Divider fields held in the oscillator control registers
    input  wire [1:0] hf_osc_divider_field_i,
    input  wire [1:0] lf_osc_divider_field_i,
    // Port I/O synchronizing strobe
    input  wire       port_io_strobe_i,
    // Selected clocks
    output reg        system_clock_o,
    output reg        usb_clock_o,
    output reg        pin_clock_o,
    output wire       periph_ext_clock_o,
    // Current selection
    output wire [2:0] sys_clock_source_field_o,
    output wire [2:0] usb_clock_source_field_o,
    output wire       pin_clock_output_sync_sel_o
);
    // Control register fields
    reg  [2:0] sys_clock_source_field;      // System clock source code
    reg  [2:0] usb_clock_source_field;      // USB clock source code
    reg        pin_clock_output_sync_sel;   // Pin clock sync select
    reg        sync_hold;                   // System tick held until the port strobe

    // Derived tick streams
    wire       hf_quarter;   // HF after fixed divide-by-four
    wire       hf_scaled;    // HF quarter after programmable divider
    wire       hf_half;      // HF halved
    wire       hf_eighth;    // HF divided by eight
    wire       ext_div2;     // External halved
    wire       ext_div3;     // External divided by three
    wire       ext_div4;     // External divided by four
    wire       lf_scaled;    // LF after programmable divider

    // Divide limits chosen by the fields
    reg  [4:0] hf_last;      // Programmable HF divider limit
    reg  [4:0] lf_last;      // Programmable LF divider limit
    reg        next_sys;     // Next system clock tick
    reg        next_usb;     // Next USB clock tick
    reg        usb_valid;    // USB code is a defined one

    // Register write; bit 7 not stored
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            sys_clock_source_field    <= `SYS_HF_SCALED;
            usb_clock_source_field    <= `USB_HF_FULL;
            pin_clock_output_sync_sel <= 1'b0;
        end else if (sfr_wr_i && (sfr_addr_i == `CSS_ADDR)) begin
            // Reserved system codes leave the old selection in place
            if (sfr_wdata_i[`SYS_FIELD_HI:`SYS_FIELD_LO] <= `SYS_LF_SCALED) begin
                sys_clock_source_field <= sfr_wdata_i[`SYS_FIELD_HI:`SYS_FIELD_LO];
            end
            usb_clock_source_field    <= sfr_wdata_i[`USB_FIELD_HI:`USB_FIELD_LO];
            pin_clock_output_sync_sel <= sfr_wdata_i[`OUT_SYNC_BIT];
        end
    end

    // Read data; bit 7 always zero, other addresses read zero
    assign sfr_rdata_o = (sfr_rd_i && (sfr_addr_i == `CSS_ADDR)) ?
        ({1'b0, usb_clock_source_field, pin_clock_output_sync_sel,
          sys_clock_source_field} & `WRITE_MASK) : 8'h00;

    // Programmable divider limits
    always @* begin
        case (hf_osc_divider_field_i)
            `HFDIV_8: hf_last = `DIV8_LAST;
            `HFDIV_4: hf_last = `DIV4_LAST;
            `HFDIV_2: hf_last = `DIV2_LAST;
            default:  hf_last = `DIV1_LAST;
        endcase
        // LF divider uses the same code table as the HF one
        case (lf_osc_divider_field_i)
            `HFDIV_8: lf_last = `DIV8_LAST;
            `HFDIV_4: lf_last = `DIV4_LAST;
            `HFDIV_2: lf_last = `DIV2_LAST;
            default:  lf_last = `DIV1_LAST;
        endcase
    end

    // Fixed divide-by-four on the 48 MHz HF source
    clk_enable_div u_hf_pre (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (hf_osc_tick_i),
        .last_i    (`PRE_DIV4_LAST),
        .tick_o    (hf_quarter)
    );

    // Programmable HF post-divider
    clk_enable_div u_hf_post (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (hf_quarter),
        .last_i    (hf_last),
        .tick_o    (hf_scaled)
    );

    // HF halved
    clk_enable_div u_hf_div2 (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (hf_osc_tick_i),
        .last_i    (`DIV2_LAST),
        .tick_o    (hf_half)
    );

    // HF divided by eight for USB
    clk_enable_div u_hf_div8 (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (hf_osc_tick_i),
        .last_i    (`DIV8_LAST),
        .tick_o    (hf_eighth)
    );

    // External halved
    clk_enable_div u_ext_div2 (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (ext_osc_tick_i),
        .last_i    (`DIV2_LAST),
        .tick_o    (ext_div2)
    );

    // External divided by three
    clk_enable_div u_ext_div3 (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (ext_osc_tick_i),
        .last_i    (`DIV3_LAST),
        .tick_o    (ext_div3)
    );

    // External divided by four
    clk_enable_div u_ext_div4 (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (ext_osc_tick_i),
        .last_i    (`DIV4_LAST),
        .tick_o    (ext_div4)
    );

    // Programmable LF post-divider
    clk_enable_div u_lf_post (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .tick_i    (lf_osc_tick_i),
        .last_i    (lf_last),
        .tick_o    (lf_scaled)
    );

    // System clock source multiplexer
    always @* begin
        case (sys_clock_source_field)
            `SYS_HF_SCALED: next_sys = hf_scaled;
            `SYS_EXT:       next_sys = ext_osc_tick_i;
            `SYS_HF_DIV2:   next_sys = hf_half;
            `SYS_HF_FULL:   next_sys = hf_osc_tick_i;
            `SYS_LF_SCALED: next_sys = lf_scaled;
            default:        next_sys = 1'b0;
        endcase
    end

    // USB clock source multiplexer
    always @* begin
        usb_valid = 1'b1;
        case (usb_clock_source_field)
            `USB_HF_FULL:  next_usb = hf_osc_tick_i;
            `USB_HF_DIV8:  next_usb = hf_eighth;
            `USB_EXT_FULL: next_usb = ext_osc_tick_i;
            `USB_EXT_DIV2: next_usb = ext_div2;
            `USB_EXT_DIV3: next_usb = ext_div3;
            `USB_EXT_DIV4: next_usb = ext_div4;
            `USB_LF_FULL:  next_usb = lf_osc_tick_i;
            default: begin
                // Reserved code gives no USB clock
                next_usb  = 1'b0;
                usb_valid = 1'b0;
            end
        endcase
    end

    // Registered clock ticks and pin output
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            system_clock_o <= 1'b0;
            usb_clock_o    <= 1'b0;
            pin_clock_o    <= 1'b0;
            sync_hold      <= 1'b0;
        end else begin
            system_clock_o <= next_sys;
            usb_clock_o    <= next_usb && usb_valid;
            // Capture a system tick until the port strobe releases it;
            // a tick on a strobe cycle leaves at once, so it is not held
            if (next_sys && !port_io_strobe_i) begin
                sync_hold <= 1'b1;
            end else if (port_io_strobe_i) begin
                sync_hold <= 1'b0;
            end
            if (pin_clock_output_sync_sel) begin
                pin_clock_o <= (sync_hold || next_sys) && port_io_strobe_i;
            end else begin
                pin_clock_o <= next_sys;
            end
        end
    end

    // External oscillator stays available to timers and capture array
    assign periph_ext_clock_o = ext_osc_tick_i;

    // Selection status
    assign sys_clock_source_field_o    = sys_clock_source_field;
    assign usb_clock_source_field_o    = usb_clock_source_field;
    assign pin_clock_output_sync_sel_o = pin_clock_output_sync_sel;
endmodule // clock_source_select_top

/* File: clock_source_select_monitor.sv */
// Port checker for the clock source select block
`timescale 1ns/1ps
module clock_source_select_monitor (
    // Clock, reset and register bus
    input wire       ref_clk_i,
    input wire       srst_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    input wire       sfr_wr_i,
    input wire       sfr_rd_i,
    input wire [7:0] sfr_rdata_o,
    // Sources and divider fields
    input wire       hf_osc_tick_i,
    input wire       ext_osc_tick_i,
    input wire       lf_osc_tick_i,
    input wire [1:0] hf_osc_divider_field_i,
    input wire [1:0] lf_osc_divider_field_i,
    input wire       port_io_strobe_i,
    // Clock outputs and fields
    input wire       system_clock_o,
    input wire       usb_clock_o,
    input wire       pin_clock_o,
    input wire       periph_ext_clock_o,
    input wire [2:0] sys_clock_source_field_o,
    input wire [2:0] usb_clock_source_field_o,
    input wire       pin_clock_output_sync_sel_o
);
    // One domain, reset masks everything
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    a_ext_periph_copy: assert property (
        periph_ext_clock_o == ext_osc_tick_i) else $error("ext copy lost");
    a_sys_ext_direct: assert property (
        sys_clock_source_field_o == 3'h1 |=> system_clock_o == $past(ext_osc_tick_i))
        else $error("sys ext path wrong");
    a_sys_hf_full: assert property (
        sys_clock_source_field_o == 3'h3 |=> system_clock_o == $past(hf_osc_tick_i))
        else $error("sys hf path wrong");
    a_usb_hf_full: assert property (
        usb_clock_source_field_o == 3'h0 |=> usb_clock_o == $past(hf_osc_tick_i))
        else $error("usb hf path wrong");
    a_usb_ext_full: assert property (
        usb_clock_source_field_o == 3'h2 |=> usb_clock_o == $past(ext_osc_tick_i))
        else $error("usb ext path wrong");
    a_usb_rsvd_quiet: assert property (
        usb_clock_source_field_o == 3'h7 |=> !usb_clock_o) else $error("usb 111 ticks");
    a_read_fields: assert property (
        sfr_rd_i && sfr_addr_i == 8'hA9 |-> sfr_rdata_o == {1'b0, usb_clock_source_field_o,
        pin_clock_output_sync_sel_o, sys_clock_source_field_o}) else $error("read wrong");
    a_raw_pin_copy: assert property (
        !pin_clock_output_sync_sel_o |=> pin_clock_o == system_clock_o)
        else $error("raw pin differs");
    a_sync_pin_strobe: assert property (
        pin_clock_output_sync_sel_o |=> !pin_clock_o || $past(port_io_strobe_i))
        else $error("sync pin off strobe");
    a_sys_rsvd_hold: assert property (
        sfr_wr_i && sfr_addr_i == 8'hA9 && sfr_wdata_i[2:0] > 3'h4
        |=> $stable(sys_clock_source_field_o)) else $error("reserved code taken");
    a_sys_write_lands: assert property (
        sfr_wr_i && sfr_addr_i == 8'hA9 && sfr_wdata_i[2:0] <= 3'h4
        |=> sys_clock_source_field_o == $past(sfr_wdata_i[2:0])) else $error("write lost");
endmodule // clock_source_select_monitor

/* File: osc_tick_model.sv */
// Free-running oscillator source giving one-cycle ticks
`timescale 1ns/1ps
module osc_tick_model #(parameter int PERIOD = 1) (
    // Reference clock and reset
    input  wire  ref_clk_i,
    input  wire  srst_i,
    // Source tick
    output logic tick_o
);
    int   cnt = 0;          // Cycles since last tick
    logic rst_seen = 1'b1;  // Reset as taken at the rising edge
    initial tick_o = 1'b0;
    // Reset copied on the rising edge, so the falling-edge count never races the bench
    always @(posedge ref_clk_i) rst_seen <= srst_i;
    // Source has no enable; count held at zero while reset is seen
    always @(negedge ref_clk_i) begin
        cnt = (rst_seen || cnt >= PERIOD - 1) ? 0 : cnt + 1;
        tick_o = (cnt == PERIOD - 1);
    end
endmodule // osc_tick_model

/* File: system_and_usb_clock_select_tb.sv */
// Testbench for the clock source select block
`timescale 1ns/1ps
`include "clk_select_defs.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %0d seen %0d", n, e, a); end end
module system_and_usb_clock_select_tb;
    logic       ref_clk_i = 0, srst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0;
    logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, d;
    logic [1:0] hf_osc_divider_field_i = 0, lf_osc_divider_field_i = 0;
    wire  [7:0] sfr_rdata_o;
    wire  [2:0] sys_clock_source_field_o, usb_clock_source_field_o;
    wire        system_clock_o, usb_clock_o, pin_clock_o, periph_ext_clock_o;
    wire        pin_clock_output_sync_sel_o, port_io_strobe_i;
    wire        hf_osc_tick_i, ext_osc_tick_i, lf_osc_tick_i;
    int         fail_count = 0, tests_run = 0, s, u, p, x;
    // Row: write, hf div, lf div, sys/usb/pin ticks per 768 cycles
    // First two rows hold the full- and low-speed USB set-ups
    typedef struct {logic [7:0] w; logic [1:0] h, l; int s, u, p;} row_t;
    row_t rows[13] = '{'{8'h00,0,0,24,768,24}, '{8'h11,0,0,384,96,384},
        '{8'h22,0,0,384,384,384}, '{8'h33,0,0,768,192,768}, '{8'h44,0,0,24,128,24},
        '{8'h50,1,0,48,96,48}, '{8'h60,2,0,96,192,96}, '{8'h00,3,0,192,768,192},
        '{8'h04,0,3,192,768,192}, '{8'h74,0,1,48,0,48}, '{8'h3B,0,0,768,192,96},
        '{8'h88,0,0,24,768,24}, '{8'h04,0,2,96,768,96}};
    always #10 ref_clk_i = ~ref_clk_i;
    clock_source_select_top i_clock_source_select_top (.*);
    // Sources at periods 1, 2, 4 and strobe every 8 cycles
    osc_tick_model #(.PERIOD(1)) i_hf (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_o(hf_osc_tick_i));
    osc_tick_model #(.PERIOD(2)) i_ext (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_o(ext_osc_tick_i));
    osc_tick_model #(.PERIOD(4)) i_lf (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_o(lf_osc_tick_i));
    osc_tick_model #(.PERIOD(8)) i_stb (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tick_o(port_io_strobe_i));
    // Register write, one strobe cycle
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk_i);
        sfr_rd_i = 0; sfr_addr_i = a; sfr_wdata_i = v; sfr_wr_i = 1;
        @(negedge ref_clk_i);
        sfr_wr_i = 0;
    endtask
    // Register read, data is combinational
    task rd(input logic [7:0] a);
        @(negedge ref_clk_i);
        sfr_addr_i = a; sfr_rd_i = 1;
        #2 d = sfr_rdata_o;
    endtask
    // Count output ticks over one common period
    task win;
        s = 0; u = 0; p = 0; x = 0;
        repeat (768) begin
            @(posedge ref_clk_i); #1;
            s += (system_clock_o === 1'b1); u += (usb_clock_o === 1'b1);
            p += (pin_clock_o === 1'b1);
            x += (periph_ext_clock_o === 1'b1);
        end
    endtask
    task summarize;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge ref_clk_i);
        srst_i = 0;
        rd(8'hA9); `CHK("reset_value", 8'h00, d);
        foreach (rows[i]) begin
            @(negedge ref_clk_i);
            hf_osc_divider_field_i = rows[i].h; lf_osc_divider_field_i = rows[i].l;
            wr(8'hA9, rows[i].w);
            rd(8'hA9); `CHK("readback", rows[i].w & `WRITE_MASK, d);
            repeat (64) @(posedge ref_clk_i);
            win;
            `CHK("sys_ticks", rows[i].s, s);
            `CHK("usb_ticks", rows[i].u, u);
            `CHK("pin_ticks", rows[i].p, p);
        end
        wr(8'hA9, 8'h07); rd(8'hA9); `CHK("reserved_sys", 8'h04, d);
        `CHK("sys_field_out", 3'h4, sys_clock_source_field_o);
        wr(8'hAA, 8'h12); rd(8'hA9); `CHK("other_addr", 8'h04, d);
        rd(8'hAA); `CHK("unmapped_read", 8'h00, d);
        wr(8'hA9, 8'h33); srst_i = 1;
        repeat (8) @(negedge ref_clk_i);
        srst_i = 0; hf_osc_divider_field_i = 0;
        rd(8'hA9); `CHK("midrun_reset", 8'h00, d);
        repeat (64) @(posedge ref_clk_i);
        win; `CHK("reset_sys", 24, s); `CHK("reset_usb", 768, u);
        `CHK("periph_ext", 384, x);
        summarize;
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        fail_count++;
        summarize;
    end
endmodule // system_and_usb_clock_select_tb
bind clock_source_select_top clock_source_select_monitor i_clock_source_select_monitor (.*);
